// file: include/asr_sram_regs.vh
// timing constants for the asynchronous sram host controller
`ifndef ASR_SRAM_REGS_VH
`define ASR_SRAM_REGS_VH
`define ASR_CLK_PERIOD_PS 5000
`define ASR_READ_CYCLE_MIN_NS 70
`define ASR_ADDRESS_ACCESS_MAX_NS 70
`define ASR_OUTPUT_ENABLE_ACCESS_MAX_NS 35
`define ASR_OUTPUT_HOLD_AFTER_ADDR_NS 10
`define ASR_ADDR_SETUP_TO_WRITE_END_NS 60
`define ASR_ADDR_SETUP_TO_WRITE_START_NS 0
`define ASR_ADDR_HOLD_AFTER_WRITE_NS 0
`define ASR_DATA_SETUP_TO_WRITE_END_NS 30
`define ASR_DATA_HOLD_AFTER_WRITE_NS 0
`define ASR_WE_PULSE_MIN_NS 55
`define ASR_WE_HIGHZ_MAX_NS 25
`define ASR_POWERDOWN_DELAY_NS 70
// least times round up to whole cycles, never below one
`define ASR_CYC_MIN(ns) ((((ns) * 1000 + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS) < 1 ? 1 : \
    (((ns) * 1000 + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS))
`define ASR_READ_CYCLES `ASR_CYC_MIN(`ASR_READ_CYCLE_MIN_NS)
`define ASR_ACCESS_CYCLES `ASR_CYC_MIN(`ASR_ADDRESS_ACCESS_MAX_NS)
`define ASR_WRITE_CYCLES `ASR_CYC_MIN(`ASR_ADDR_SETUP_TO_WRITE_END_NS)
`define ASR_HIGHZ_CYCLES `ASR_CYC_MIN(`ASR_WE_HIGHZ_MAX_NS)
`define ASR_PD_CYCLES `ASR_CYC_MIN(`ASR_POWERDOWN_DELAY_NS)
`endif

// file: rtl/asr_sync.v
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module asr_sync #(
    parameter WIDTH = 8
) (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // first stage feeds only the second
    always @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // asr_sync
`default_nettype wire

// file: rtl/asr_host.v
// host controller driving an asynchronous 512k x 8 static ram over its pins
//
// Contract
// - write lasts for overlap of select low and strobe low; either rise ends it.
// - host gives data 30 ns set-up and 0 ns hold to write end.
// - host holds address through write; valid 60 ns before write end.
// - reads at least 70 ns apart; data valid 70 ns after address.
// - host must not drive data pins while memory still drives them.
// - address valid before or with select falling on a read.
`timescale 1ns/1ps
`default_nettype none
`include "asr_sram_regs.vh"
module asr_host #(
    parameter ADDR_W = 19,
    parameter DATA_W = 8
) (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_req_valid,
    input wire i_req_write,
    input wire [ADDR_W-1:0] i_req_addr,
    input wire [DATA_W-1:0] i_req_wdata,
    output wire o_req_ready,
    output reg [DATA_W-1:0] o_rsp_rdata,
    output reg o_rsp_valid,
    output reg [ADDR_W-1:0] o_address_inputs,
    output reg o_chip_sel_n,
    output reg o_out_en_n,
    output reg o_write_n,
    input wire [DATA_W-1:0] i_data_pins,
    output reg [DATA_W-1:0] o_data_pins,
    output reg o_data_pins_oe
);
    localparam CW = 6;
    // header cycle counts are integers; the counter keeps their low bits
    localparam integer ACC_CYC_I = `ASR_ACCESS_CYCLES;
    localparam integer WR_CYC_I = `ASR_WRITE_CYCLES;
    localparam integer HZ_CYC_I = `ASR_HIGHZ_CYCLES;
    localparam [CW-1:0] ACC_CYC = ACC_CYC_I[CW-1:0];
    localparam [CW-1:0] WR_CYC = WR_CYC_I[CW-1:0];
    localparam [CW-1:0] HZ_CYC = HZ_CYC_I[CW-1:0];
    // two extra cycles cover the input synchroniser latency
    localparam [CW-1:0] SAMPLE_CYC = ACC_CYC + 6'd2;

    // controller states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_READ = 3'd1;
    localparam [2:0] ST_WR_FLOAT = 3'd2;
    localparam [2:0] ST_WRITE = 3'd3;
    localparam [2:0] ST_RECOVER = 3'd4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;
    wire [DATA_W-1:0] rdata_sync;

    // data pins pass two flip-flops before the read capture
    asr_sync #(
        .WIDTH(DATA_W)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_async(i_data_pins),
        .o_sync(rdata_sync)
    );

    // requests are taken only in idle
    assign o_req_ready = (state_reg == ST_IDLE);

    // next state and cycle counter
    always @*
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE:
            begin
                cnt_next = 6'd0;
                if (i_req_valid)
                    state_next = i_req_write ? ST_WR_FLOAT : ST_READ;
            end
            ST_READ:
            begin
                cnt_next = cnt_reg + 6'd1;
                if (cnt_reg == SAMPLE_CYC)
                begin
                    state_next = ST_RECOVER;
                    cnt_next = 6'd0;
                end
            end
            ST_WR_FLOAT:
            begin
                cnt_next = cnt_reg + 6'd1;
                if (cnt_reg + 6'd1 >= HZ_CYC)
                begin
                    state_next = ST_WRITE;
                    cnt_next = 6'd0;
                end
            end
            ST_WRITE:
            begin
                cnt_next = cnt_reg + 6'd1;
                if (cnt_reg + 6'd1 >= WR_CYC)
                begin
                    state_next = ST_RECOVER;
                    cnt_next = 6'd0;
                end
            end
            ST_RECOVER:
            begin
                cnt_next = cnt_reg + 6'd1;
                if (cnt_reg + 6'd1 >= 6'd2)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
                cnt_next = 6'd0;
            end
        endcase
    end

    // state, pins and response registers
    always @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            // memory deselected and pins released in reset
            state_reg <= ST_IDLE;
            cnt_reg <= 6'd0;
            o_address_inputs <= {ADDR_W{1'b0}};
            o_chip_sel_n <= 1'b1;
            o_out_en_n <= 1'b1;
            o_write_n <= 1'b1;
            o_data_pins <= {DATA_W{1'b0}};
            o_data_pins_oe <= 1'b0;
            o_rsp_rdata <= {DATA_W{1'b0}};
            o_rsp_valid <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            o_rsp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (i_req_valid)
                    begin
                        // address goes out with select, never after it
                        o_address_inputs <= i_req_addr;
                        o_chip_sel_n <= 1'b0;
                        o_out_en_n <= i_req_write;
                        o_write_n <= 1'b1;
                        o_data_pins <= i_req_wdata;
                        o_data_pins_oe <= 1'b0;
                    end
                    else
                    begin
                        // park the pins so the memory stays in power-down
                        o_chip_sel_n <= 1'b1;
                        o_out_en_n <= 1'b1;
                        o_write_n <= 1'b1;
                        o_data_pins_oe <= 1'b0;
                    end
                end
                ST_READ:
                begin
                    if (cnt_reg == SAMPLE_CYC)
                    begin
                        o_rsp_rdata <= rdata_sync;
                        o_rsp_valid <= 1'b1;
                        o_chip_sel_n <= 1'b1;
                        o_out_en_n <= 1'b1;
                    end
                end
                ST_WR_FLOAT:
                begin
                    // memory outputs already disabled; start write and drive data
                    if (cnt_reg + 6'd1 >= HZ_CYC)
                    begin
                        o_write_n <= 1'b0;
                        o_data_pins_oe <= 1'b1;
                    end
                end
                ST_WRITE:
                begin
                    // strobe and select rise together, address and data held
                    if (cnt_reg + 6'd1 >= WR_CYC)
                    begin
                        o_write_n <= 1'b1;
                        o_chip_sel_n <= 1'b1;
                    end
                end
                ST_RECOVER:
                begin
                    // data released one cycle after write end, zero hold met
                    o_data_pins_oe <= 1'b0;
                end
                default:
                begin
                    o_chip_sel_n <= 1'b1;
                    o_write_n <= 1'b1;
                    o_out_en_n <= 1'b1;
                    o_data_pins_oe <= 1'b0;
                end
            endcase
        end
    end
endmodule // asr_host
`default_nettype wire

// file: bench/asr_host_assertions.sv
// pin timing assertions for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module asr_host_chk (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [18:0] i_req_addr,
    input wire logic o_rsp_valid,
    input wire logic [18:0] o_address_inputs,
    input wire logic o_chip_sel_n,
    input wire logic o_out_en_n,
    input wire logic o_write_n,
    input wire logic [7:0] o_data_pins,
    input wire logic o_data_pins_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    no_contention_a: assert property (o_data_pins_oe |-> o_out_en_n) else $error("host drives during read");
    end_together_a: assert property ($rose(o_write_n) |-> $rose(o_chip_sel_n)) else $error("strobe ends alone");
    data_setup_a: assert property ($rose(o_write_n) |-> $past(o_data_pins_oe, 6)) else $error("data setup short");
    data_hold_a: assert property (!o_write_n |=> $stable(o_data_pins)) else $error("data moved in write");
    addr_hold_a: assert property (!o_chip_sel_n && $past(!o_chip_sel_n) |-> $stable(o_address_inputs))
        else $error("address moved while selected");
    addr_setup_a: assert property ($rose(o_write_n) |-> $past(!o_chip_sel_n, 12)) else $error("address setup short");
    read_len_a: assert property ($rose(o_out_en_n) |-> $past(!o_out_en_n, 14)) else $error("read too short");
    read_addr_a: assert property (i_req_valid && !i_req_write && $past(o_rsp_valid) == 0 && o_chip_sel_n && o_write_n
        ##1 $fell(o_out_en_n) |-> !o_chip_sel_n && o_address_inputs == $past(i_req_addr)) else $error("read address late");
    rsp_time_a: assert property ($fell(o_out_en_n) |-> ##17 o_rsp_valid) else $error("read answer late");
    no_strobe_read_a: assert property (!o_out_en_n |-> o_write_n) else $error("strobe during read");
endmodule // asr_host_chk
bind asr_host asr_host_chk asr_host_chk_i (.i_clk_sys, .i_resetn, .i_req_valid, .i_req_write, .i_req_addr,
    .o_rsp_valid, .o_address_inputs, .o_chip_sel_n, .o_out_en_n, .o_write_n, .o_data_pins, .o_data_pins_oe);
`default_nettype wire

// file: bench/asr_sram_model.sv
// behavioural 512k x 8 asynchronous static ram
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
    input wire logic [18:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_host_d,
    input wire logic i_host_oe,
    input wire logic [31:0] i_acc_ns,
    output logic [7:0] o_pins
);
    logic [7:0] mem [bit [18:0]];
    logic [7:0] rd_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [18:0] wa;
    logic [7:0] wd;
    logic act = 1'b0;
    wire drv = !i_cs_n && !i_oe_n && i_we_n;
    // capture during overlap, commit at the ending edge
    always @*
        if (!i_cs_n && !i_we_n) begin wa = i_addr; wd = o_pins; act = 1'b1; end
        else if (act) begin mem[wa] = wd; act = 1'b0; end
    // read data lag, old data kept meanwhile
    always @(i_addr or drv) rd_q <= #(i_acc_ns * 1ns) (mem.exists(i_addr) ? mem[i_addr] : 8'h00);
    always @(o_pins) if (i_host_oe || drv) last_q <= o_pins;
    // released bus shows the inverse of the last level
    assign o_pins = i_host_oe ? i_host_d : (drv ? rd_q : ~last_q);
endmodule // asr_sram_model
`default_nettype wire

// file: bench/async_sram_512k_x8_test.sv
// self-checking bench for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module async_sram_512k_x8_test;
    logic clk = 1'b0, rstn = 1'b0, valid = 1'b0, write = 1'b0;
    logic [18:0] addr = 19'h0_0000, sa;
    logic [7:0] wdata = 8'h00, rdata, hd, pins;
    logic ready, rsp_valid, cs_n, oe_n, we_n, hoe;
    logic [18:0] pa;
    int acc = 10, error_cnt = 0, tests_run = 0, cyc = 0, r;
    logic [7:0] shadow [bit [18:0]];
    // expected read value: last byte written to that address
    function automatic logic [7:0] exp_read(input logic [18:0] a);
        return shadow.exists(a) ? shadow[a] : 8'h00;
    endfunction
    asr_host asr_host_i (.i_clk_sys(clk), .i_resetn(rstn), .i_req_valid(valid), .i_req_write(write),
        .i_req_addr(addr), .i_req_wdata(wdata), .o_req_ready(ready), .o_rsp_rdata(rdata), .o_rsp_valid(rsp_valid),
        .o_address_inputs(pa), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_write_n(we_n), .i_data_pins(pins),
        .o_data_pins(hd), .o_data_pins_oe(hoe));
    asr_sram_model asr_sram_model_i (.i_addr(pa), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_host_d(hd),
        .i_host_oe(hoe), .i_acc_ns(acc), .o_pins(pins));
    initial forever #2.5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin cyc++; if (cyc == 20000) begin error_cnt++; stop_test(); end end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, s); end
    endtask
    // one request, read answers compared with the shadow copy
    task automatic req(input logic w, input logic [18:0] a, input logic [7:0] d);
        do @(negedge clk); while (ready !== 1'b1);
        valid = 1'b1; write = w; addr = a; wdata = d;
        @(negedge clk);
        valid = 1'b0;
        if (w) begin
            shadow[a] = d;
            do @(negedge clk); while (ready !== 1'b1);
            check("ram cell", asr_sram_model_i.mem[a], d);
            check("idle select", {7'h00, cs_n}, 8'h01);
        end else begin
            do @(negedge clk); while (rsp_valid !== 1'b1);
            check("read data", rdata, exp_read(a));
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        r = $urandom(88);
        repeat (5) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        // corners: lowest and highest address, slow and fast memory
        acc = 70;
        req(1'b1, 19'h0_0000, 8'hA5);
        req(1'b1, 19'h7_FFFF, 8'h5A);
        req(1'b0, 19'h0_0000, 8'h00);
        acc = 10;
        req(1'b0, 19'h7_FFFF, 8'h00);
        req(1'b1, 19'h7_FFFF, 8'h3C);
        req(1'b0, 19'h7_FFFF, 8'h00);
        $display("corner test done");
        // random mix on a small address pool
        repeat (60) begin
            acc = 10 + $urandom % 61;
            sa = {2'($urandom), 15'h0000, 2'($urandom)};
            if (shadow.exists(sa) && $urandom % 2) req(1'b0, sa, 8'h00);
            else req(1'b1, sa, 8'($urandom));
        end
        $display("random test done");
        stop_test();
    end
endmodule // async_sram_512k_x8_test
`default_nettype wire
